// ===== core/rsh_cfg.svh
`ifndef RSH_CFG_SVH
`define RSH_CFG_SVH
// Operation
// - Each reference has its own integer divider, programmable 1 to 1023.
// - Presence of each divided reference is monitored and steers switchover.
// - Manual reference choice comes from a register bit or the select pin.
// - Automatic mode moves to secondary when primary is lost and secondary present.
// - Nonrevertive mode stays on secondary until the secondary itself disappears.
// - Revertive mode returns to primary as soon as primary is present again.
// - Both references absent means holdover, running on the oscillator alone.
// - Holdover tristates the charge pump unless mid-supply forcing is selected.
// - Holdover ends once a reference is present; the loop then resynchronizes.
// - Control bit 6 forces the charge pump to half supply during holdover.
// - Secondary divider reuses primary value unless control bit 7 is set.
// - A lone present reference is active; with both, the other is backup.

// ****************************************
// Register map (byte addresses)
// ****************************************
`define RSH_OFS_DIV_PRI  12'h000
`define RSH_OFS_DIV_SEC  12'h004
`define RSH_OFS_STATUS   12'h008
`define RSH_OFS_IRQ_STS  12'h00c
`define RSH_OFS_IRQ_MASK 12'h010
`define RSH_OFS_CTRL     12'h01c

// ****************************************
// Reset values and fields
// ****************************************
`define RSH_DIV_RST      10'h001
`define RSH_CTRL_RST     8'h00
`define RSH_IRQ_RST      5'h00
`define RSH_EV_PRI_LOST  0
`define RSH_EV_SEC_LOST  1
`define RSH_EV_SWITCH    2
`define RSH_EV_HOLD_IN   3
`define RSH_EV_HOLD_OUT  4

// ****************************************
// Timing
// ****************************************
`define RSH_CLK_MHZ      10
`define RSH_MON_WIN_US   200
`endif

// ===== core/rsh_pkg.sv
package rsh_pkg;
    // Control register layout
    typedef struct packed {
        logic       indep_div;
        logic       force_mid;
        logic [1:0] spare;
        logic       revertive;
        logic       pin_sel_en;
        logic       manual_sel;
        logic       manual_en;
    } rsh_ctrl_t;

    // Charge pump drive seen by the analog loop
    typedef struct packed {
        logic tristate;
        logic force_mid;
    } rsh_cp_t;

    typedef enum logic [1:0] {
        RSH_ON_PRI,
        RSH_ON_SEC,
        RSH_HOLD
    } rsh_state_t;
endpackage : rsh_pkg

// ===== core/rsh_top.sv
`include "rsh_cfg.svh"

module rsh_top (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Reference pins
    input  wire logic             primary_reference,
    input  wire logic             secondary_reference,
    input  wire logic             ref_select_pin,
    // Loop side
    output logic                  pfd_ref_pulse,
    output logic                  sel_secondary,
    output logic                  holdover,
    output rsh_pkg::rsh_cp_t      charge_pump,
    output logic                  irq
);
    localparam int         WIN_CYC = `RSH_MON_WIN_US * `RSH_CLK_MHZ;
    localparam logic [11:0] WIN_LIM = 12'(WIN_CYC - 1);

    // ****************************************
    // Registers
    // ****************************************
    logic [9:0]          div_pri_reg;
    logic [9:0]          div_sec_reg;
    rsh_pkg::rsh_ctrl_t  ctrl_reg;
    logic [4:0]          irq_sts_reg;
    logic [4:0]          irq_mask_reg;
    logic [4:0]          irq_sts_next;
    logic [4:0]          ev;
    rsh_pkg::rsh_state_t state_reg;
    rsh_pkg::rsh_state_t state_next;
    logic [1:0]          sel_sync_reg;
    logic [1:0]          pres;
    logic [1:0]          div_pulse;
    logic                acc;
    logic                hit;
    logic                want_sec;
    logic [31:0]         rd_mux;

    // ****************************************
    // Reference select pin synchroniser
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_sync_reg <= 2'h0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], ref_select_pin};
        end
    end

    // ****************************************
    // Per-reference divider and monitor
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ref
            logic [2:0]  sync_reg;
            logic [9:0]  edge_cnt_reg;
            logic [11:0] idle_cnt_reg;
            logic        pres_reg;
            logic        pulse;
            logic [9:0]  dv;
            logic [9:0]  lim;
            logic        rise;
            // Secondary may share the primary ratio
            assign dv = (gi == 0 || !ctrl_reg.indep_div) ? div_pri_reg : div_sec_reg;
            // A ratio of zero is taken as one
            assign lim = (dv == 10'h000) ? 10'h000 : dv - 10'h001;
            assign rise = sync_reg[1] & ~sync_reg[2];
            assign pulse = rise && (edge_cnt_reg >= lim);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_reg <= 3'h0;
                end else begin
                    sync_reg <= {sync_reg[1:0], (gi == 0) ? primary_reference
                                                          : secondary_reference};
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    edge_cnt_reg <= 10'h000;
                end else if (pulse) begin
                    edge_cnt_reg <= 10'h000;
                end else if (rise) begin
                    edge_cnt_reg <= edge_cnt_reg + 10'h001;
                end
            end
            // Window must exceed the slowest divided period or presence flaps
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    idle_cnt_reg <= 12'h000;
                    pres_reg     <= 1'b0;
                end else if (pulse) begin
                    idle_cnt_reg <= 12'h000;
                    pres_reg     <= 1'b1;
                end else if (idle_cnt_reg >= WIN_LIM) begin
                    pres_reg     <= 1'b0;
                end else begin
                    idle_cnt_reg <= idle_cnt_reg + 12'h001;
                end
            end
            assign pres[gi]      = pres_reg;
            assign div_pulse[gi] = pulse;
        end
    endgenerate

    // ****************************************
    // Switchover control
    // ****************************************
    assign want_sec = ctrl_reg.pin_sel_en ? sel_sync_reg[1] : ctrl_reg.manual_sel;

    always_comb begin
        state_next = state_reg;
        if (pres == 2'b00) begin
            state_next = rsh_pkg::RSH_HOLD;
        end else if (ctrl_reg.manual_en) begin
            // Lone present reference wins over the manual choice
            if (!pres[0] || (want_sec && pres[1])) begin
                state_next = rsh_pkg::RSH_ON_SEC;
            end else begin
                state_next = rsh_pkg::RSH_ON_PRI;
            end
        end else begin
            case (state_reg)
                rsh_pkg::RSH_ON_PRI: begin
                    if (!pres[0]) begin
                        state_next = rsh_pkg::RSH_ON_SEC;
                    end
                end
                rsh_pkg::RSH_ON_SEC: begin
                    if (!pres[1]) begin
                        state_next = rsh_pkg::RSH_ON_PRI;
                    end else if (ctrl_reg.revertive && pres[0]) begin
                        state_next = rsh_pkg::RSH_ON_PRI;
                    end
                end
                rsh_pkg::RSH_HOLD: begin
                    state_next = pres[0] ? rsh_pkg::RSH_ON_PRI
                                         : rsh_pkg::RSH_ON_SEC;
                end
                default: state_next = rsh_pkg::RSH_HOLD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= rsh_pkg::RSH_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Loop side outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_secondary         <= 1'b0;
            holdover              <= 1'b1;
            charge_pump.tristate  <= 1'b1;
            charge_pump.force_mid <= 1'b0;
            pfd_ref_pulse         <= 1'b0;
        end else begin
            sel_secondary         <= (state_reg == rsh_pkg::RSH_ON_SEC);
            holdover              <= (state_reg == rsh_pkg::RSH_HOLD);
            charge_pump.tristate  <= (state_reg == rsh_pkg::RSH_HOLD)
                                     && !ctrl_reg.force_mid;
            charge_pump.force_mid <= (state_reg == rsh_pkg::RSH_HOLD)
                                     && ctrl_reg.force_mid;
            // Pulses resume to the detector so the loop relocks
            pfd_ref_pulse         <= (state_reg == rsh_pkg::RSH_ON_PRI) ? div_pulse[0]
                                   : (state_reg == rsh_pkg::RSH_ON_SEC) ? div_pulse[1]
                                   : 1'b0;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // One fixed wait-free access phase keeps the master logic trivial
    assign acc = psel && penable && pready;
    assign hit = (paddr == `RSH_OFS_DIV_PRI) || (paddr == `RSH_OFS_DIV_SEC)
              || (paddr == `RSH_OFS_STATUS) || (paddr == `RSH_OFS_IRQ_STS)
              || (paddr == `RSH_OFS_IRQ_MASK) || (paddr == `RSH_OFS_CTRL);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `RSH_OFS_DIV_PRI:  rd_mux = {22'h000000, div_pri_reg};
            `RSH_OFS_DIV_SEC:  rd_mux = {22'h000000, div_sec_reg};
            `RSH_OFS_STATUS:   rd_mux = {26'h0000000, charge_pump.force_mid,
                                         charge_pump.tristate, holdover,
                                         sel_secondary, pres};
            `RSH_OFS_IRQ_STS:  rd_mux = {27'h0000000, irq_sts_reg};
            `RSH_OFS_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_reg};
            `RSH_OFS_CTRL:     rd_mux = {24'h000000, ctrl_reg};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_pri_reg  <= `RSH_DIV_RST;
            div_sec_reg  <= `RSH_DIV_RST;
            ctrl_reg     <= `RSH_CTRL_RST;
            irq_mask_reg <= `RSH_IRQ_RST;
        end else if (acc && pwrite) begin
            case (paddr)
                `RSH_OFS_DIV_PRI:  div_pri_reg  <= pwdata[9:0];
                `RSH_OFS_DIV_SEC:  div_sec_reg  <= pwdata[9:0];
                `RSH_OFS_IRQ_MASK: irq_mask_reg <= pwdata[4:0];
                `RSH_OFS_CTRL:     ctrl_reg     <= pwdata[7:0];
                default:           ctrl_reg     <= ctrl_reg;
            endcase
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_comb begin
        ev = 5'h00;
        ev[`RSH_EV_PRI_LOST] = (state_reg == rsh_pkg::RSH_ON_PRI)
                               && (state_next != rsh_pkg::RSH_ON_PRI) && !pres[0];
        ev[`RSH_EV_SEC_LOST] = (state_reg == rsh_pkg::RSH_ON_SEC)
                               && (state_next != rsh_pkg::RSH_ON_SEC) && !pres[1];
        ev[`RSH_EV_SWITCH]   = (state_reg != rsh_pkg::RSH_HOLD)
                               && (state_next != rsh_pkg::RSH_HOLD)
                               && (state_next != state_reg);
        ev[`RSH_EV_HOLD_IN]  = (state_reg != rsh_pkg::RSH_HOLD)
                               && (state_next == rsh_pkg::RSH_HOLD);
        ev[`RSH_EV_HOLD_OUT] = (state_reg == rsh_pkg::RSH_HOLD)
                               && (state_next != rsh_pkg::RSH_HOLD);
    end

    // New events beat the read clear
    assign irq_sts_next = ((acc && !pwrite && paddr == `RSH_OFS_IRQ_STS) ? 5'h00
                          : irq_sts_reg) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_reg <= `RSH_IRQ_RST;
            irq         <= 1'b0;
        end else begin
            irq_sts_reg <= irq_sts_next;
            irq         <= |(irq_sts_next & irq_mask_reg);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_hold_entry: assert property ((pres == 2'b00) |=>
        state_reg == rsh_pkg::RSH_HOLD ##1 holdover) else $error("holdover not entered");
    chk_auto_switch: assert property (!ctrl_reg.manual_en && !pres[0] && pres[1]
        && state_reg == rsh_pkg::RSH_ON_PRI |=> state_reg == rsh_pkg::RSH_ON_SEC)
        else $error("no switch to secondary");
    chk_nonrevert_stay: assert property (!ctrl_reg.manual_en && !ctrl_reg.revertive
        && pres[1] && state_reg == rsh_pkg::RSH_ON_SEC |=> state_reg == rsh_pkg::RSH_ON_SEC)
        else $error("left secondary while present");
    chk_revert_back: assert property (!ctrl_reg.manual_en && ctrl_reg.revertive
        && pres == 2'b11 && state_reg == rsh_pkg::RSH_ON_SEC
        |=> state_reg == rsh_pkg::RSH_ON_PRI) else $error("no revert to primary");
    chk_cp_tristate: assert property ($rose(state_reg == rsh_pkg::RSH_HOLD)
        && !ctrl_reg.force_mid |-> ##1 charge_pump.tristate) else $error("pump driven");
    chk_cp_midsupply: assert property (state_reg == rsh_pkg::RSH_HOLD
        && ctrl_reg.force_mid |=> charge_pump.force_mid && !charge_pump.tristate)
        else $error("pump not at mid supply");
    chk_hold_exit: assert property (state_reg == rsh_pkg::RSH_HOLD && pres != 2'b00
        |=> state_reg != rsh_pkg::RSH_HOLD ##1 !holdover) else $error("stuck in holdover");
    chk_lone_ref: assert property (pres == 2'b10 |=> state_reg == rsh_pkg::RSH_ON_SEC)
        else $error("lone secondary not used");
    chk_monitor_win: assert property (g_ref[0].idle_cnt_reg >= WIN_LIM
        && !div_pulse[0] |=> !pres[0]) else $error("absence not declared");
    chk_irq_level: assert property ((irq_sts_reg & irq_mask_reg) != 5'h00
        && $stable(irq_mask_reg) |-> irq) else $error("interrupt missing");
    chk_irq_quiet: assert property (irq |-> irq_sts_reg != 5'h00)
        else $error("spurious interrupt");
endmodule : rsh_top

// ===== verif/rsh_ref_src.sv
// ****************************************
// Reference clock source
// ****************************************
module rsh_ref_src #(
    parameter int HALF_NS  = 400,
    parameter int PHASE_NS = 30
) (
    // Control
    input  wire logic enable,
    // Reference pin
    output logic      ref_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Offset from pclk edges so the pin never moves on a sampling edge
    initial begin
        ref_out = 1'b0;
        #PHASE_NS;
        forever begin
            #HALF_NS;
            // Stopped source parks low, like a dead oscillator output
            ref_out = enable ? ~ref_out : 1'b0;
        end
    end
endmodule : rsh_ref_src

// ===== verif/rsh_top_tb.sv
module rsh_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Signals
    // ****************************************
    logic             pclk, presetn, psel, penable, pwrite, ref_select_pin;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rdat;
    logic             pready, pslverr, pfd_ref_pulse, sel_secondary, holdover, irq;
    logic             primary_reference, secondary_reference, pri_en, sec_en, rerr;
    rsh_pkg::rsh_cp_t charge_pump;
    int               fails, compares, cyc;

    rsh_top rsh_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .primary_reference(primary_reference),
        .secondary_reference(secondary_reference), .ref_select_pin(ref_select_pin),
        .pfd_ref_pulse(pfd_ref_pulse), .sel_secondary(sel_secondary), .holdover(holdover),
        .charge_pump(charge_pump), .irq(irq));
    rsh_ref_src rsh_ref_src_inst (.enable(pri_en), .ref_out(primary_reference));
    rsh_ref_src sec_src_inst (.enable(sec_en), .ref_out(secondary_reference));

    initial begin
        pclk = 1'b0;
    end
    always #50 pclk = ~pclk;

    // ****************************************
    // Common tasks
    // ****************************************
    task automatic end_sim();
        $display("Counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Holdover, tristate, force_mid as one field
    task automatic chk_cp(input logic [2:0] exp);
        chk({29'h0, holdover, charge_pump.tristate, charge_pump.force_mid}, {29'h0, exp});
    endtask : chk_cp

    task automatic chk_sel(input logic exp);
        chk({31'h0, sel_secondary}, {31'h0, exp});
    endtask : chk_sel

    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk

    // Spacing in cycles between divided pulses of the active reference
    task automatic gap(input int exp);
        int n;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pfd_ref_pulse !== 1'b1 && n < 500);
        end
        chk(n, exp);
    endtask : gap

    // Monitor window is 2000 cycles; a little margin for sync flops
    task automatic lose();
        repeat (2100) @(posedge pclk);
    endtask : lose

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk_cp(3'b110);
        rd_chk(12'h000, 32'h1);
        rd_chk(12'h004, 32'h1);
        rd_chk(12'h01c, 32'h0);
        rd_chk(12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'hff);
        rd_chk(12'h008, 32'h18);
        rd_chk(12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_auto();
        pri_en <= 1'b1;
        sec_en <= 1'b1;
        // Settling wait before the loop is judged locked
        repeat (100) @(posedge pclk);
        chk_cp(3'b000);
        chk_sel(1'b0);
        rd_chk(12'h008, 32'h03);
        pri_en <= 1'b0;
        lose();
        chk_sel(1'b1);
        chk({31'h0, irq}, 32'h0);
        pri_en <= 1'b1;
        repeat (200) @(posedge pclk);
        chk_sel(1'b1);
        sec_en <= 1'b0;
        lose();
        chk_sel(1'b0);
        sec_en <= 1'b1;
        $display("test auto done");
    endtask : t_auto

    task automatic t_revert();
        apb(1'b1, 12'h01c, 32'h08);
        pri_en <= 1'b0;
        lose();
        chk_sel(1'b1);
        pri_en <= 1'b1;
        repeat (200) @(posedge pclk);
        chk_sel(1'b0);
        $display("test revert done");
    endtask : t_revert

    task automatic t_hold();
        apb(1'b1, 12'h010, 32'h08);
        apb(1'b0, 12'h00c, 32'h0);
        // Backup drops first so the loss order is fixed
        sec_en <= 1'b0;
        repeat (100) @(posedge pclk);
        pri_en <= 1'b0;
        lose();
        chk_cp(3'b110);
        chk({31'h0, irq}, 32'h1);
        rd_chk(12'h00c, 32'h09);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h01c, 32'h48);
        repeat (3) @(posedge pclk);
        chk_cp(3'b101);
        rd_chk(12'h008, 32'h28);
        pri_en <= 1'b1;
        repeat (100) @(posedge pclk);
        chk_cp(3'b000);
        chk_sel(1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rdat & 32'h10, 32'h10);
        $display("test holdover done");
    endtask : t_hold

    task automatic t_manual();
        sec_en <= 1'b1;
        repeat (100) @(posedge pclk);
        apb(1'b1, 12'h01c, 32'h03);
        repeat (4) @(posedge pclk);
        chk_sel(1'b1);
        apb(1'b1, 12'h01c, 32'h07);
        repeat (6) @(posedge pclk);
        chk_sel(1'b0);
        ref_select_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_sel(1'b1);
        sec_en <= 1'b0;
        lose();
        chk_sel(1'b0);
        sec_en <= 1'b1;
        ref_select_pin <= 1'b0;
        $display("test manual done");
    endtask : t_manual

    task automatic t_div();
        apb(1'b1, 12'h01c, 32'h00);
        apb(1'b1, 12'h000, 32'h7ff);
        rd_chk(12'h000, 32'h3ff);
        apb(1'b1, 12'h000, 32'h3);
        gap(24);
        apb(1'b1, 12'h004, 32'h5);
        apb(1'b1, 12'h01c, 32'h03);
        gap(24);
        apb(1'b1, 12'h01c, 32'h83);
        gap(40);
        $display("test divider done");
    endtask : t_div

    // ****************************************
    // Main sequence and timeout
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, ref_select_pin, pri_en, sec_en} = 7'h0;
        paddr  = 12'h0;
        pwdata = 32'h0;
        fails = 0;
        compares = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_auto();
        t_revert();
        t_hold();
        t_manual();
        t_div();
        end_sim();
    end

    // About 11700 cycles expected; generous ceiling
    initial begin
        cyc = 0;
        forever begin
            @(posedge pclk);
            cyc++;
            if (cyc == 40000) begin
                fails++;
                end_sim();
            end
        end
    end
endmodule : rsh_top_tb
